// [core/rcad_core.sv]
// rcad_core: 8-bit core with accumulator, ALU, status flags, pc and stack.
// assumes a program rom and data ram on CLK that answer in the same cycle.
`timescale 1ns/1ns
module rcad_core (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic RC_MODE,
    output logic [12:0] PROG_ADDR,
    input wire logic [13:0] PROG_DATA,
    output logic [7:0] DATA_ADDR,
    input wire logic [7:0] DATA_RDATA,
    output logic [7:0] DATA_WDATA,
    output logic DATA_WE,
    output logic INSTR_RATE_OUT,
    output logic [7:0] ACC,
    output logic [7:0] STATUS_OUT
);
    rcad_pkg::rcad_phase_t q;
    rcad_pkg::rcad_alu_t r;
    logic [13:0] ir;
    logic [7:0] opnd;
    logic [7:0] fsr;
    logic [12:0] stack [rcad_pkg::STACK_DEPTH];
    logic [2:0] sp;
    logic rc_m;
    logic rc_s;
    logic do_skip;
    logic do_goto;
    logic do_call;
    logic do_ret;
    logic jump;
    logic [2:0] sel;
    logic [7:0] eff;
    logic [7:0] next_status;

    // one-hot {fsr, status, pcl}; banks mirror the core registers
    function automatic logic [2:0] core_reg(input logic [7:0] a);
        core_reg = {a[6:0] == rcad_pkg::ADDR_FSR, a[6:0] == rcad_pkg::ADDR_STATUS,
                    a[6:0] == rcad_pkg::ADDR_PCL};
    endfunction

    function automatic rcad_pkg::rcad_alu_t add8(input logic [7:0] a, input logic [7:0] b,
                                                 input logic cin);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        add8 = '0;
        add8.val = s[7:0];
        add8.c = s[8];
        add8.dc = n[4];
        add8.c_en = 1'b1;
        add8.dc_en = 1'b1;
        add8.z_en = 1'b1;
    endfunction

    // pin input: two flops before use
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rc_m <= 1'b0;
            rc_s <= 1'b0;
        end else begin
            rc_m <= RC_MODE;
            rc_s <= rc_m;
        end
    end

    // four phases per instruction cycle; reset pin is asynchronous
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            q <= rcad_pkg::RCAD_Q1;
        end else begin
            unique case (q)
                rcad_pkg::RCAD_Q1: q <= rcad_pkg::RCAD_Q2;
                rcad_pkg::RCAD_Q2: q <= rcad_pkg::RCAD_Q3;
                rcad_pkg::RCAD_Q3: q <= rcad_pkg::RCAD_Q4;
                rcad_pkg::RCAD_Q4: q <= rcad_pkg::RCAD_Q1;
            endcase
        end
    end

    // high during the second half of each cycle, low when not in RC mode
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            INSTR_RATE_OUT <= 1'b0;
        end else begin
            INSTR_RATE_OUT <= rc_s && (q == rcad_pkg::RCAD_Q2 || q == rcad_pkg::RCAD_Q3);
        end
    end

    // address 0 goes through the pointer register
    assign eff = (ir[6:0] == rcad_pkg::ADDR_INDIRECT) ? fsr : {1'b0, ir[6:0]};
    assign sel = core_reg(eff);

    // operand read in Q2; core registers answer instead of the data bus
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            DATA_ADDR <= 8'h00;
            opnd <= 8'h00;
        end else begin
            if (q == rcad_pkg::RCAD_Q1) begin
                DATA_ADDR <= eff;
            end
            if (q == rcad_pkg::RCAD_Q2) begin
                if (sel[0]) begin
                    opnd <= PROG_ADDR[7:0];
                end else if (sel[1]) begin
                    opnd <= STATUS_OUT;
                end else if (sel[2]) begin
                    opnd <= fsr;
                end else begin
                    opnd <= DATA_RDATA;
                end
            end
        end
    end

    // execute: valid through Q3 and Q4 while ir, opnd and ACC hold
    always_comb begin
        r = '0;
        do_skip = 1'b0;
        do_goto = 1'b0;
        do_call = 1'b0;
        do_ret = 1'b0;
        case (ir[13:12])
            2'b00: begin
                r.to_f = ir[7];
                r.to_w = !ir[7];
                r.z_en = 1'b1;
                case (ir[11:8])
                    4'h0: begin
                        r.val = ACC;
                        r.z_en = 1'b0;
                        r.to_w = 1'b0;
                        do_ret = !ir[7] && ir[6:1] == 6'h04;
                    end
                    4'h1: r.val = 8'h00;
                    4'h2: r = add8(opnd, ~ACC, 1'b1);
                    4'h3: r.val = opnd - 8'h01;
                    4'h4: r.val = opnd | ACC;
                    4'h5: r.val = opnd & ACC;
                    4'h6: r.val = opnd ^ ACC;
                    4'h7: r = add8(opnd, ACC, 1'b0);
                    4'h8: r.val = opnd;
                    4'h9: r.val = ~opnd;
                    4'ha: r.val = opnd + 8'h01;
                    4'hb: begin
                        r.val = opnd - 8'h01;
                        r.z_en = 1'b0;
                        do_skip = r.val == 8'h00;
                    end
                    4'hc: begin
                        r.val = {STATUS_OUT[rcad_pkg::BIT_C], opnd[7:1]};
                        r.c = opnd[0];
                        r.c_en = 1'b1;
                        r.z_en = 1'b0;
                    end
                    4'hd: begin
                        r.val = {opnd[6:0], STATUS_OUT[rcad_pkg::BIT_C]};
                        r.c = opnd[7];
                        r.c_en = 1'b1;
                        r.z_en = 1'b0;
                    end
                    4'he: begin
                        r.val = {opnd[3:0], opnd[7:4]};
                        r.z_en = 1'b0;
                    end
                    default: begin
                        r.val = opnd + 8'h01;
                        r.z_en = 1'b0;
                        do_skip = r.val == 8'h00;
                    end
                endcase
                if (ir[11:8] == 4'h2 || ir[11:8] == 4'h7) begin
                    r.to_f = ir[7];
                    r.to_w = !ir[7];
                end
            end
            2'b01: begin
                r.val = opnd;
                r.val[ir[9:7]] = ir[10];
                r.to_f = !ir[11];
                do_skip = ir[11] && (opnd[ir[9:7]] == ir[10]);
            end
            2'b10: begin
                do_goto = ir[11];
                do_call = !ir[11];
            end
            default: begin
                r.to_w = 1'b1;
                r.z_en = 1'b1;
                case (ir[11:8])
                    4'h8: r.val = ir[7:0] | ACC;
                    4'h9: r.val = ir[7:0] & ACC;
                    4'ha: r.val = ir[7:0] ^ ACC;
                    4'hb: r = '0; // spare literal slot: no write and no flag update
                    4'hc, 4'hd: r = add8(ir[7:0], ~ACC, 1'b1);
                    4'he, 4'hf: r = add8(ir[7:0], ACC, 1'b0);
                    default: begin
                        r.val = ir[7:0];
                        r.z_en = 1'b0;
                        do_ret = ir[10];
                    end
                endcase
                if (ir[11:9] >= 3'h6) begin
                    r.to_w = 1'b1;
                end
            end
        endcase
    end

    assign jump = do_skip || do_goto || do_call || do_ret || (r.to_f && sel[0]);

    always_comb begin
        next_status = (r.to_f && sel[1]) ? r.val : STATUS_OUT;
        if (r.z_en) begin
            next_status[rcad_pkg::BIT_Z] = r.val == 8'h00;
        end
        if (r.c_en) begin
            next_status[rcad_pkg::BIT_C] = r.c;
        end
        if (r.dc_en) begin
            next_status[rcad_pkg::BIT_DC] = r.dc;
        end
    end

    // commits at the end of Q4; the accumulator has no data address
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ACC <= 8'h00;
            STATUS_OUT <= rcad_pkg::STATUS_RESET;
            fsr <= rcad_pkg::FSR_RESET;
        end else if (q == rcad_pkg::RCAD_Q4) begin
            if (r.to_w) begin
                ACC <= r.val;
            end
            STATUS_OUT <= next_status;
            if (r.to_f && sel[2]) begin
                fsr <= r.val;
            end
        end
    end

    // external file write strobes for one clock during Q4
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            DATA_WE <= 1'b0;
            DATA_WDATA <= 8'h00;
        end else begin
            DATA_WE <= q == rcad_pkg::RCAD_Q3 && r.to_f && sel == 3'b000;
            if (q == rcad_pkg::RCAD_Q3) begin
                DATA_WDATA <= r.val;
            end
        end
    end

    // fetch runs one cycle ahead; a jump drops the fetched word
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PROG_ADDR <= rcad_pkg::PC_RESET;
            ir <= rcad_pkg::NOP_WORD;
            sp <= 3'h0;
            for (int i = 0; i < rcad_pkg::STACK_DEPTH; i++) begin
                stack[i] <= rcad_pkg::PC_RESET;
            end
        end else if (q == rcad_pkg::RCAD_Q4) begin
            ir <= jump ? rcad_pkg::NOP_WORD : PROG_DATA;
            if (do_goto || do_call) begin
                PROG_ADDR <= {PROG_ADDR[12:11], ir[10:0]};
            end else if (do_ret) begin
                PROG_ADDR <= stack[sp - 3'h1];
            end else if (r.to_f && sel[0]) begin
                PROG_ADDR <= {PROG_ADDR[12:8], r.val};
            end else begin
                PROG_ADDR <= PROG_ADDR + 13'h0001;
            end
            if (do_call) begin
                stack[sp] <= PROG_ADDR;
                sp <= sp + 3'h1;
            end else if (do_ret) begin
                sp <= sp - 3'h1;
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    a_phase_onehot: assert property ($onehot(q))
        else $error("phase not one-hot");
    a_cycle_length: assert property (q == rcad_pkg::RCAD_Q1 |=> ##2 q == rcad_pkg::RCAD_Q4 ##1
        q == rcad_pkg::RCAD_Q1) else $error("cycle is not four clocks");
    a_fetch_stable: assert property (q != rcad_pkg::RCAD_Q1 |-> $stable(PROG_ADDR))
        else $error("program address moved inside a cycle");
    a_pc_step: assert property (q == rcad_pkg::RCAD_Q4 && !jump |=>
        PROG_ADDR == $past(PROG_ADDR) + 13'h0001 && ir == $past(PROG_DATA)) else $error("fetch did not step");
    a_branch_flush: assert property (q == rcad_pkg::RCAD_Q4 && jump |=> ir == rcad_pkg::NOP_WORD
        ##3 !DATA_WE) else $error("branch did not flush");
    a_rate_high: assert property ((q == rcad_pkg::RCAD_Q3 || q == rcad_pkg::RCAD_Q4) |->
        INSTR_RATE_OUT == $past(rc_s)) else $error("rate output wrong in second half");
    a_rate_low: assert property ((q == rcad_pkg::RCAD_Q1 || q == rcad_pkg::RCAD_Q2) |->
        !INSTR_RATE_OUT) else $error("rate output high in first half");
    a_zero_flag: assert property (q == rcad_pkg::RCAD_Q4 && r.z_en |=>
        STATUS_OUT[rcad_pkg::BIT_Z] == ($past(r.val) == 8'h00)) else $error("zero flag wrong");
    a_sub_borrow: assert property (q == rcad_pkg::RCAD_Q4 && ir[13:8] == 6'h02 |=>
        STATUS_OUT[rcad_pkg::BIT_C] == ($past(opnd) >= $past(ACC))) else $error("borrow flag wrong");
    a_add_acc: assert property (q == rcad_pkg::RCAD_Q4 && ir[13:7] == 7'h0e |=>
        ACC == 8'($past(opnd) + $past(ACC))) else $error("add result wrong");
    a_we_external: assert property (DATA_WE |-> q == rcad_pkg::RCAD_Q4 && sel == 3'b000
        ##1 !DATA_WE) else $error("write strobe misplaced");

    c_call_taken: cover property (q == rcad_pkg::RCAD_Q4 && do_call);
    c_skip_taken: cover property (q == rcad_pkg::RCAD_Q4 && do_skip);
    c_sub_borrow: cover property (q == rcad_pkg::RCAD_Q4 && ir[13:8] == 6'h02 && opnd < ACC);
    c_rate_out: cover property (INSTR_RATE_OUT ##2 !INSTR_RATE_OUT);
endmodule // rcad_core

// [shared/rcad_pkg.sv]
// rcad_pkg: constants and types of the 8-bit core datapath.
// assumes one 100 MHz clock; four clocks make one instruction cycle.
package rcad_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int INSTR_CYCLE_NS = 40;
    localparam int CLKS_PER_INSTR = INSTR_CYCLE_NS / CLK_PERIOD_NS;
    localparam int INSTR_W = 14;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] FSR_RESET = 8'h00;
    localparam logic [13:0] NOP_WORD = 14'h0000;
    localparam logic [6:0] ADDR_INDIRECT = 7'h00;
    localparam logic [6:0] ADDR_PCL = 7'h02;
    localparam logic [6:0] ADDR_STATUS = 7'h03;
    localparam logic [6:0] ADDR_FSR = 7'h04;
    localparam int BIT_C = 0;
    localparam int BIT_DC = 1;
    localparam int BIT_Z = 2;

    typedef enum logic [3:0] {
        RCAD_Q1 = 4'h1,
        RCAD_Q2 = 4'h2,
        RCAD_Q3 = 4'h4,
        RCAD_Q4 = 4'h8
    } rcad_phase_t;

    typedef struct packed {
        logic [7:0] val;
        logic c;
        logic dc;
        logic c_en;
        logic dc_en;
        logic z_en;
        logic to_w;
        logic to_f;
    } rcad_alu_t;
endpackage

// [testbench/test_risc_core_alu_datapath.sv]
// test_risc_core_alu_datapath: self-checking bench of the 8-bit core datapath.
// assumes rcad_core with a combinational program rom and data ram, both modelled here.
`timescale 1ns/1ns
module test_risc_core_alu_datapath;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic RC_MODE = 1'b0;
    logic [12:0] PROG_ADDR;
    logic [13:0] PROG_DATA;
    logic [7:0] DATA_ADDR;
    logic [7:0] DATA_RDATA;
    logic [7:0] DATA_WDATA;
    logic DATA_WE;
    logic INSTR_RATE_OUT;
    logic [7:0] ACC;
    logic [7:0] STATUS_OUT;
    logic [13:0] rom [0:8191];
    logic [7:0] ram [0:255];
    int err_count = 0;
    int comparisons = 0;

    always #(rcad_pkg::CLK_PERIOD_NS / 2) CLK = ~CLK;

    assign PROG_DATA = rom[PROG_ADDR];
    assign DATA_RDATA = ram[DATA_ADDR];
    always @(posedge CLK) begin
        if (DATA_WE === 1'b1) begin
            ram[DATA_ADDR] <= DATA_WDATA;
        end
    end

    rcad_core uut (
        .CLK(CLK),
        .RESET_N(RESET_N),
        .RC_MODE(RC_MODE),
        .PROG_ADDR(PROG_ADDR),
        .PROG_DATA(PROG_DATA),
        .DATA_ADDR(DATA_ADDR),
        .DATA_RDATA(DATA_RDATA),
        .DATA_WDATA(DATA_WDATA),
        .DATA_WE(DATA_WE),
        .INSTR_RATE_OUT(INSTR_RATE_OUT),
        .ACC(ACC),
        .STATUS_OUT(STATUS_OUT)
    );

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic check_addr(input logic [12:0] got, input logic [12:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic clear_mem();
        for (int i = 0; i < 8192; i++) begin
            rom[i] = 14'h0000;
        end
        for (int i = 0; i < 256; i++) begin
            ram[i] = 8'h00;
        end
    endtask

    // returns at the falling edge of release; the next rising edge ends Q1 of cycle 0
    task automatic do_reset(input logic rc);
        @(negedge CLK);
        RESET_N = 1'b0;
        RC_MODE = rc;
        repeat (8) @(negedge CLK);
        RESET_N = 1'b1;
    endtask

    // file 0x20 gets a, then w gets b, then op runs; a self-loop branch parks the core
    task automatic run_op(input logic [13:0] op, input logic [7:0] a, input logic [7:0] b,
                          input logic [7:0] exp_w, input logic [7:0] exp_st, input logic [7:0] exp_f);
        clear_mem();
        rom[0] = 14'h3000 | {6'h00, a};
        rom[1] = 14'h00a0;
        rom[2] = 14'h3000 | {6'h00, b};
        rom[3] = op;
        rom[4] = 14'h2804;
        do_reset(1'b0);
        repeat (10 * rcad_pkg::CLKS_PER_INSTR) @(negedge CLK);
        check_byte(ACC, exp_w, "acc");
        check_byte(STATUS_OUT, exp_st, "status");
        check_byte(ram[8'h20], exp_f, "file 0x20");
    endtask

    task automatic test_reset_mid();
        clear_mem();
        rom[0] = 14'h30a5;
        rom[1] = 14'h3e70;
        rom[2] = 14'h2802;
        do_reset(1'b1);
        repeat (22) @(negedge CLK);
        check_byte(ACC, 8'h15, "acc before reset");
        check_byte(STATUS_OUT, 8'h19, "status before reset");
        check_bit(INSTR_RATE_OUT, 1'b1, "rate in q3");
        RESET_N = 1'b0;
        #1;
        check_addr(PROG_ADDR, 13'h0000, "pc in reset");
        check_byte(ACC, 8'h00, "acc in reset");
        check_byte(STATUS_OUT, 8'h18, "status in reset");
        check_bit(DATA_WE, 1'b0, "write strobe in reset");
        check_byte(DATA_ADDR, 8'h00, "data address in reset");
        check_byte(DATA_WDATA, 8'h00, "write data in reset");
        check_bit(INSTR_RATE_OUT, 1'b0, "rate in reset");
        repeat (8) @(negedge CLK);
        check_addr(PROG_ADDR, 13'h0000, "pc held in reset");
        RESET_N = 1'b1;
        repeat (22) @(negedge CLK);
        check_byte(ACC, 8'h15, "acc after rerun");
    endtask

    task automatic test_arith();
        run_op(14'h3e08, 8'h00, 8'hf8, 8'h00, 8'h1f, 8'h00);
        run_op(14'h3c10, 8'h00, 8'h01, 8'h0f, 8'h19, 8'h00);
        run_op(14'h3c01, 8'h00, 8'h02, 8'hff, 8'h18, 8'h00);
        run_op(14'h3c05, 8'h00, 8'h05, 8'h00, 8'h1f, 8'h00);
    endtask

    task automatic test_logic();
        run_op(14'h39f0, 8'h00, 8'h0f, 8'h00, 8'h1c, 8'h00);
        run_op(14'h3850, 8'h00, 8'h0a, 8'h5a, 8'h18, 8'h00);
        run_op(14'h3aff, 8'h00, 8'hff, 8'h00, 8'h1c, 8'h00);
        run_op(14'h0100, 8'h12, 8'h34, 8'h00, 8'h1c, 8'h12);
    endtask

    task automatic test_file_ops();
        run_op(14'h0720, 8'h0f, 8'h01, 8'h10, 8'h1a, 8'h0f);
        run_op(14'h02a0, 8'h03, 8'h05, 8'h05, 8'h18, 8'hfe);
        run_op(14'h0d20, 8'h81, 8'h00, 8'h02, 8'h19, 8'h81);
        run_op(14'h0ca0, 8'h01, 8'h77, 8'h77, 8'h19, 8'h00);
        run_op(14'h0820, 8'h00, 8'h44, 8'h00, 8'h1c, 8'h00);
        // status read back through its data address
        run_op(14'h0803, 8'h00, 8'h11, 8'h18, 8'h18, 8'h00);
        run_op(14'h17a0, 8'h01, 8'h00, 8'h00, 8'h18, 8'h81);
        run_op(14'h0920, 8'h0f, 8'h00, 8'hf0, 8'h18, 8'h0f);
        run_op(14'h0ea0, 8'h12, 8'h00, 8'h00, 8'h18, 8'h21);
        run_op(14'h03a0, 8'h01, 8'h00, 8'h00, 8'h1c, 8'h00);
    endtask

    // nested call and return, then a taken bit-test skip over a clear of the file
    task automatic test_calls();
        clear_mem();
        rom[0] = 14'h2010;
        rom[1] = 14'h00a1;
        rom[2] = 14'h1821;
        rom[3] = 14'h01a1;
        rom[4] = 14'h0a21;
        rom[5] = 14'h2805;
        rom[13'h0010] = 14'h2012;
        rom[13'h0011] = 14'h3442;
        rom[13'h0012] = 14'h0008;
        do_reset(1'b0);
        repeat (20 * rcad_pkg::CLKS_PER_INSTR) @(negedge CLK);
        check_byte(ram[8'h21], 8'h42, "file 0x21 after return");
        check_byte(ACC, 8'h43, "acc after skip");
        check_byte(STATUS_OUT, 8'h18, "status after skip");
    endtask

    // pointer loaded through its data address, file reached through address 0, then a pc low write
    task automatic test_indirect();
        clear_mem();
        rom[0] = 14'h3020;
        rom[1] = 14'h0084;
        rom[2] = 14'h305a;
        rom[3] = 14'h0080;
        rom[4] = 14'h0a80;
        rom[5] = 14'h3008;
        rom[6] = 14'h0082;
        rom[7] = 14'h01a0;
        rom[8] = 14'h2808;
        do_reset(1'b0);
        repeat (20 * rcad_pkg::CLKS_PER_INSTR) @(negedge CLK);
        check_byte(ram[8'h20], 8'h5b, "file reached through pointer");
        check_byte(ram[8'h04], 8'h00, "pointer kept off the data bus");
        check_byte(ram[8'h02], 8'h00, "pc low kept off the data bus");
        check_byte(ACC, 8'h08, "acc after computed jump");
    endtask

    task automatic test_branch();
        logic [12:0] exp_pc [0:7] = '{13'h0000, 13'h0001, 13'h0002, 13'h0003,
                                      13'h0010, 13'h0011, 13'h0012, 13'h0011};
        clear_mem();
        rom[2] = 14'h2810;
        rom[3] = 14'h3055;
        rom[13'h0010] = 14'h3033;
        rom[13'h0011] = 14'h2811;
        do_reset(1'b0);
        for (int k = 0; k < 8; k++) begin
            @(negedge CLK);
            check_addr(PROG_ADDR, exp_pc[k], "fetch address");
            check_byte(ACC, (k < 6) ? 8'h00 : 8'h33, "acc across branch");
            repeat (3) @(negedge CLK);
        end
    endtask

    task automatic test_rate_out();
        clear_mem();
        do_reset(1'b1);
        // a whole number of instruction cycles keeps the phase count aligned
        repeat (8) @(negedge CLK);
        for (int i = 0; i < 16; i++) begin
            @(negedge CLK);
            check_bit(INSTR_RATE_OUT, (i % 4 == 1) || (i % 4 == 2), "rate output");
        end
        RC_MODE = 1'b0;
        repeat (4) @(negedge CLK);
        for (int i = 0; i < 8; i++) begin
            @(negedge CLK);
            check_bit(INSTR_RATE_OUT, 1'b0, "rate output off");
        end
    endtask

    initial begin
        test_reset_mid();
        test_arith();
        test_logic();
        test_file_ops();
        test_branch();
        test_calls();
        test_indirect();
        test_rate_out();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge CLK);
        err_count++;
        $display("[ERR] %0t run exceeded its cycle limit", $time);
        finish_test();
    end
endmodule // test_risc_core_alu_datapath
